// File: tb/low_power_clock_handshake_test.sv
// Self-checking bench for the low-power clock handshake
module low_power_clock_handshake_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, bus_busy, wake_req, enter, leave;
  logic csysreq, csysack, cactive, low, denied, pd, pu;
  lp_handshake_pkg::lp_mode_t lp_mode;
  int err_count = 0;
  int compares = 0;
  // ********************
  // Device and controller
  // ********************
  lp_clock_handshake uut (.sys_clk(sys_clk), .rstn(rstn),
    .csysreq(csysreq), .csysack(csysack), .cactive(cactive),
    .lp_mode(lp_mode), .bus_busy(bus_busy), .wake_req(wake_req),
    .in_low_power(low), .req_denied(denied), .powering_down(pd),
    .powering_up(pu));
  lp_ctrl_model ctrl (.sys_clk(sys_clk), .rstn(rstn), .enter(enter),
    .leave(leave), .cactive(cactive), .csysack(csysack),
    .csysreq(csysreq));
  // Free-running 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // Sampled mid-cycle so edge updates have landed
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (csysack !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > 100) begin
        err_count++;
        $display("ERROR wait_ack timeout expected %b seen %b", lvl, csysack);
        final_report();
      end
    end
  endtask : wait_ack
  task automatic enter_low(input logic exp_cact);
    @(posedge sys_clk);
    enter <= 1'b1;
    wait_ack(1'b0);
    check("cactive at ack", cactive, exp_cact);
    check("denied at ack", denied, exp_cact);
    @(posedge sys_clk);
    enter <= 1'b0;
  endtask : enter_low
  task automatic leave_low();
    @(posedge sys_clk);
    leave <= 1'b1;
    wait_ack(1'b1);
    @(posedge sys_clk);
    leave <= 1'b0;
  endtask : leave_low
  task automatic accept_exit();
    enter_low(1'b0);
    check("in low power", low, 1'b1);
    leave_low();
    check("cactive after exit", cactive, 1'b1);
  endtask : accept_exit
  task automatic deny_busy();
    @(posedge sys_clk);
    bus_busy <= 1'b1;
    enter_low(1'b1);
    wait_ack(1'b1);
    check("low after deny", low, 1'b0);
    @(posedge sys_clk);
    bus_busy <= 1'b0;
  endtask : deny_busy
  task automatic wake_exit();
    enter_low(1'b0);
    @(posedge sys_clk);
    wake_req <= 1'b1;
    wait_ack(1'b1);
    check("cactive after wake", cactive, 1'b1);
    @(posedge sys_clk);
    wake_req <= 1'b0;
  endtask : wake_exit
  // Always-on refuses; gate-any gives the clock up at once
  task automatic mode_check();
    @(posedge sys_clk);
    lp_mode <= lp_handshake_pkg::MODE_ALWAYS_ON;
    enter_low(1'b1);
    wait_ack(1'b1);
    // Busy must not block a tied-low peripheral
    @(posedge sys_clk);
    lp_mode <= lp_handshake_pkg::MODE_GATE_ANY;
    bus_busy <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check("gate-any cactive", cactive, 1'b0);
    enter_low(1'b0);
    check("gate-any low", low, 1'b1);
    leave_low();
    bus_busy <= 1'b0;
    lp_mode <= lp_handshake_pkg::MODE_SEQUENCED;
  endtask : mode_check
  // Reset, then each scenario in turn
  initial begin
    rstn = 1'b0;
    bus_busy = 1'b0;
    wake_req = 1'b0;
    enter = 1'b0;
    leave = 1'b0;
    lp_mode = lp_handshake_pkg::MODE_SEQUENCED;
    repeat (6) @(posedge sys_clk);
    check("ack in reset", csysack, 1'b1);
    check("cactive in reset", cactive, 1'b1);
    rstn <= 1'b1;
    accept_exit();
    deny_busy();
    accept_exit();
    wake_exit();
    mode_check();
    repeat (3) @(posedge sys_clk);
    final_report();
  end
endmodule : low_power_clock_handshake_test

// File: tb/lp_ctrl_model.sv
// Clock controller model driving the request line
module lp_ctrl_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic enter,
  input wire logic leave,
  input wire logic cactive,
  input wire logic csysack,
  output logic csysreq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Never re-requests before the previous cycle closed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      csysreq <= 1'b1;
    end else if (csysreq && csysack && enter) begin
      csysreq <= 1'b0;
    end else if (!csysreq && !csysack && (cactive || leave)) begin
      csysreq <= 1'b1;
    end
  end
endmodule : lp_ctrl_model

// File: tb/lp_handshake_sva.sv
// Checker for the low-power clock handshake ports
module lp_handshake_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic csysreq,
  input wire logic csysack,
  input wire logic cactive,
  input wire lp_handshake_pkg::lp_mode_t lp_mode,
  input wire logic bus_busy,
  input wire logic wake_req,
  input wire logic in_low_power,
  input wire logic req_denied,
  input wire logic powering_down,
  input wire logic powering_up
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Handshake properties
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic seq_m;
  logic gate_m;
  // Timed sequences only apply to sequenced peripherals
  assign seq_m = (lp_mode == lp_handshake_pkg::MODE_SEQUENCED);
  // Tied-low class always accepts, busy or not
  assign gate_m = (lp_mode == lp_handshake_pkg::MODE_GATE_ANY);
  chk_ack_fall_order: assert property ($fell(csysack) |-> !csysreq)
    else $error("ack fell while request high");
  chk_ack_rise_order: assert property ($rose(csysack) |-> csysreq)
    else $error("ack rose while request low");
  chk_clock_before_ack: assert property
    ($fell(csysack) && !cactive |-> $past(cactive) == 1'b0)
    else $error("cactive fell with ack");
  chk_busy_deny: assert property
    ($fell(csysreq) && csysack && bus_busy && !gate_m |=>
     !csysack && cactive && req_denied)
    else $error("busy request not denied");
  chk_pdown_time: assert property
    ($fell(csysreq) && csysack && !bus_busy && !wake_req && seq_m |=>
     powering_down [*4] ##1 (!cactive && !powering_down) ##1 !csysack)
    else $error("power-down timing wrong");
  chk_pup_time: assert property
    ($rose(csysreq) && in_low_power && !cactive && seq_m |=>
     powering_up [*8] ##1 cactive ##1 csysack)
    else $error("power-up timing wrong");
  chk_exit_active: assert property ($rose(csysack) && seq_m |-> cactive)
    else $error("exit ack without clock demand");
  chk_wake_exit: assert property
    (in_low_power && wake_req && !csysreq && !cactive && seq_m |=> cactive)
    else $error("wake did not raise cactive");
  // Main scenarios reached
  cover property ($fell(csysack) && !cactive);
  cover property ($fell(csysack) && cactive);
  cover property (in_low_power && wake_req);
endmodule : lp_handshake_sva

bind lp_clock_handshake lp_handshake_sva chk (.sys_clk(sys_clk),
  .rstn(rstn), .csysreq(csysreq), .csysack(csysack), .cactive(cactive),
  .lp_mode(lp_mode), .bus_busy(bus_busy), .wake_req(wake_req),
  .in_low_power(in_low_power), .req_denied(req_denied),
  .powering_down(powering_down), .powering_up(powering_up));

// File: verilog/lp_clock_handshake.sv
// Device-side sequencer for the low-power clock control handshake
//
// Contract
// - Raising cactive demands the clock at once
// - Lowering cactive leaves gating to the controller
// - Gate-any ties cactive low, always-on high
// - Sequenced peripherals enter low power only on request
// - csysack acknowledges both entry and exit
// - Four-phase: req falls, ack falls, req rises, ack rises
// - cactive level at ack fall: low accept, high deny
// - Accept: see request, power down, cactive low, ack
// - Low power is cactive and csysreq both low; in_low_power also stays high in ST_WAKE_WAIT, with cactive high
// - Controller exit: req rises, power up, cactive, ack
// - Peripheral may hold ack low until exit done
// - Inputs sampled on rising edge, outputs change after
`include "lp_handshake_consts.svh"

module lp_clock_handshake (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic csysreq,
  output logic csysack,
  output logic cactive,
  input wire lp_handshake_pkg::lp_mode_t lp_mode,
  input wire logic bus_busy,
  input wire logic wake_req,
  output logic in_low_power,
  output logic req_denied,
  output logic powering_down,
  output logic powering_up
);

  // ****************************************************
  // State
  // ****************************************************
  lp_handshake_pkg::lp_state_t state_q;
  lp_handshake_pkg::lp_state_t state_d;
  logic cactive_q;
  logic cactive_d;
  logic ack_q;
  logic ack_d;
  logic denied_q;
  logic denied_d;
  logic busy_now;
  logic must_deny;
  logic wake_exit_ok;
  logic low_q;
  logic pdown_q;
  logic pup_q;

  seq_timer_if tmr_if ();

  seq_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tmr(tmr_if)
  );

  // Pending bus work or local wake gets an entry request denied, except in gate-any
  assign busy_now = bus_busy || wake_req;

  // Always-on never gives its clock up; busy work must finish first
  assign must_deny = busy_now ||
                     (lp_mode == lp_handshake_pkg::MODE_ALWAYS_ON);

  // A tied-low peripheral has no wake of its own to act on
  assign wake_exit_ok = wake_req &&
                        (lp_mode != lp_handshake_pkg::MODE_GATE_ANY);

  // ****************************************************
  // Sequencer
  // ****************************************************
  // All decisions use inputs as sampled at the rising edge; outputs
  // are flops, so there is no input-to-output combinational path.
  always_comb begin
    state_d = state_q;
    cactive_d = cactive_q;
    ack_d = ack_q;
    denied_d = 1'b0;
    tmr_if.start = 1'b0;
    tmr_if.cycles = `LP_TIMER_W'(`LP_PDOWN_CYCLES);
    unique case (state_q)
      lp_handshake_pkg::ST_RUN: begin
        cactive_d = 1'b1;
        // Entry only starts from the controller's request
        if (!csysreq) begin
          if (lp_mode == lp_handshake_pkg::MODE_GATE_ANY) begin
            // Cactive is tied low, so this class can only accept
            state_d = lp_handshake_pkg::ST_PD_ACK;
          end else if (must_deny) begin
            state_d = lp_handshake_pkg::ST_DENY;
            ack_d = 1'b0; // Ack with cactive still high
            denied_d = 1'b1;
          end else begin
            state_d = lp_handshake_pkg::ST_PDOWN;
            tmr_if.start = 1'b1;
          end
        end
      end
      lp_handshake_pkg::ST_PDOWN: begin
        // Drop cactive only after the power-down work ends
        if (tmr_if.done) begin
          cactive_d = 1'b0;
          state_d = lp_handshake_pkg::ST_PD_ACK;
        end
      end
      lp_handshake_pkg::ST_PD_ACK: begin
        // cactive already low here, so this ack accepts
        ack_d = 1'b0;
        state_d = lp_handshake_pkg::ST_LOW;
      end
      lp_handshake_pkg::ST_LOW: begin
        // Either side driving high starts the exit
        if (csysreq) begin
          state_d = lp_handshake_pkg::ST_PUP;
          tmr_if.start = 1'b1;
          tmr_if.cycles = `LP_TIMER_W'(`LP_PUP_CYCLES);
        end else if (wake_exit_ok) begin
          cactive_d = 1'b1; // Peripheral-led exit
          state_d = lp_handshake_pkg::ST_WAKE_WAIT;
        end
      end
      lp_handshake_pkg::ST_WAKE_WAIT: begin
        // Ack stays low until the controller answers
        if (csysreq) begin
          state_d = lp_handshake_pkg::ST_PUP;
          tmr_if.start = 1'b1;
          tmr_if.cycles = `LP_TIMER_W'(`LP_PUP_CYCLES);
        end
      end
      lp_handshake_pkg::ST_PUP: begin
        // Power-up work, then cactive before ack
        if (tmr_if.done) begin
          cactive_d = 1'b1;
          state_d = lp_handshake_pkg::ST_PU_ACK;
        end
      end
      lp_handshake_pkg::ST_PU_ACK: begin
        ack_d = 1'b1; // Exit acknowledged
        state_d = lp_handshake_pkg::ST_RUN;
      end
      lp_handshake_pkg::ST_DENY: begin
        // Wait for the controller to close the denied handshake
        if (csysreq) begin
          ack_d = 1'b1;
          state_d = lp_handshake_pkg::ST_RUN;
        end
      end
    endcase
    // Tied classes override the sequenced level
    if (lp_mode == lp_handshake_pkg::MODE_GATE_ANY) begin
      cactive_d = 1'b0;
    end else if (lp_mode == lp_handshake_pkg::MODE_ALWAYS_ON) begin
      cactive_d = 1'b1;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // State register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= lp_handshake_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Clock demand, high out of reset so the clock runs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cactive_q <= `LP_CACTIVE_RST;
    end else begin
      cactive_q <= cactive_d;
    end
  end

  // Handshake acknowledge, high in normal operation
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= `LP_ACK_RST;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Denial pulse for the local side
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      denied_q <= 1'b0;
    end else begin
      denied_q <= denied_d;
    end
  end

  // Low-power status, taken from the next state so it tracks state_q
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      low_q <= 1'b0;
    end else begin
      low_q <= (state_d == lp_handshake_pkg::ST_LOW) ||
               (state_d == lp_handshake_pkg::ST_WAKE_WAIT);
    end
  end

  // Power-down work in progress
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pdown_q <= 1'b0;
    end else begin
      pdown_q <= (state_d == lp_handshake_pkg::ST_PDOWN);
    end
  end

  // Power-up work in progress
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pup_q <= 1'b0;
    end else begin
      pup_q <= (state_d == lp_handshake_pkg::ST_PUP);
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign csysack = ack_q;
  assign cactive = cactive_q;
  assign req_denied = denied_q;
  assign in_low_power = low_q;
  assign powering_down = pdown_q;
  assign powering_up = pup_q;

endmodule : lp_clock_handshake

// File: verilog/lp_handshake_consts.svh
// Timing counts and reset values for the low-power clock handshake
`ifndef LP_HANDSHAKE_CONSTS_SVH
`define LP_HANDSHAKE_CONSTS_SVH

// Clock rate of sys_clk in MHz
`define LP_CLK_MHZ 20
// Least time for the internal power-down work, in ns
`define LP_PDOWN_TIME_NS 200
// Least time for the internal power-up work, in ns
`define LP_PUP_TIME_NS 400
// Least times round up to whole cycles
`define LP_PDOWN_CYCLES ((`LP_PDOWN_TIME_NS * `LP_CLK_MHZ + 999) / 1000)
`define LP_PUP_CYCLES ((`LP_PUP_TIME_NS * `LP_CLK_MHZ + 999) / 1000)
// Width of the sequence timer
`define LP_TIMER_W 8
// Reset levels of the handshake outputs
`define LP_CACTIVE_RST 1'b1
`define LP_ACK_RST 1'b1

`endif

// File: verilog/lp_handshake_pkg.sv
// Types shared by the low-power clock handshake design
package lp_handshake_pkg;

  // Handshake sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_PDOWN = 3'h1,
    ST_PD_ACK = 3'h2,
    ST_LOW = 3'h3,
    ST_WAKE_WAIT = 3'h4,
    ST_PUP = 3'h5,
    ST_PU_ACK = 3'h6,
    ST_DENY = 3'h7
  } lp_state_t;

  // Peripheral class seen by the clock controller
  typedef enum logic [1:0] {
    MODE_SEQUENCED = 2'h0,
    MODE_GATE_ANY = 2'h1,
    MODE_ALWAYS_ON = 2'h2
  } lp_mode_t;

endpackage : lp_handshake_pkg

// File: verilog/seq_timer.sv
// Down counter that times the power-down and power-up work
`include "lp_handshake_consts.svh"

module seq_timer (
  input wire logic sys_clk,
  input wire logic rstn,
  seq_timer_if.timer tmr
);

  logic [`LP_TIMER_W-1:0] count_q;
  logic running_q;

  // ****************************************************
  // Count
  // ****************************************************
  // Start reloads the count; done is a one-cycle pulse at the end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (tmr.start) begin
      count_q <= tmr.cycles;
      running_q <= 1'b1;
    end else if (running_q) begin
      count_q <= count_q - `LP_TIMER_W'(1);
      if (count_q == `LP_TIMER_W'(1)) begin
        running_q <= 1'b0;
      end
    end
  end

  assign tmr.done = running_q && (count_q == `LP_TIMER_W'(1));

endmodule : seq_timer

// File: verilog/seq_timer_if.sv
// Carrier between the handshake sequencer and its sequence timer
`include "lp_handshake_consts.svh"

interface seq_timer_if;
  logic start;
  logic [`LP_TIMER_W-1:0] cycles;
  logic done;

  modport ctrl (output start, output cycles, input done);
  modport timer (input start, input cycles, output done);
endinterface : seq_timer_if
